// ### hw/lsd_line_state_detector.sv
// Line state detector: dead and live line decision for three phases.
// Assumes samples and block_in synchronous to pclk; APB master drives regs.
// Function
// [R1] Take sampled voltages and currents of all three phases as inputs.
// [R2] Estimate fundamental magnitude of each of six channels separately.
// [R3] Dead line only when all voltages and all currents are below threshold.
// [R4] Live line only when all three voltages exceed threshold.
// [R5] Enable setting off or on, off after reset; off means no outputs.
// [R6] Voltage threshold percent, 10 to 100, step 1, default 60.
// [R7] Current threshold percent, 2 to 100, step 1, default 10.
// [R8] Active block input disables function and holds all outputs inactive.
// [R9] One flag per phase, active while voltage is above threshold.
// [R10] One flag per phase, active while current is above threshold.
// [R11] Decide dead and live outputs from flags, enable and block input.
// [R12] Thresholds are percent of nominal; compare once per clock.
// [R13] Outputs stay inactive until estimators fill their first window.
module lsd_line_state_detector
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sampled measurements
    input wire logic smp_valid,
    input wire logic signed [LSD_SMP_W-1:0] phase_a_voltage,
    input wire logic signed [LSD_SMP_W-1:0] phase_b_voltage,
    input wire logic signed [LSD_SMP_W-1:0] phase_c_voltage,
    input wire logic signed [LSD_SMP_W-1:0] phase_a_current,
    input wire logic signed [LSD_SMP_W-1:0] phase_b_current,
    input wire logic signed [LSD_SMP_W-1:0] phase_c_current,
    // Block input
    input wire logic block_in,
    // Per-phase flags
    output logic volt_above_a,
    output logic volt_above_b,
    output logic volt_above_c,
    output logic curr_above_a,
    output logic curr_above_b,
    output logic curr_above_c,
    // Line state
    output logic dead_line_out,
    output logic live_line_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic signed [LSD_SMP_W-1:0] smp_arr [LSD_NCH];
    logic [LSD_MAG_W-1:0] mag_arr [LSD_NCH];
    logic [LSD_NCH-1:0] mag_ok;
    logic [LSD_NCH-1:0] above;
    logic [LSD_CMP_W-1:0] lim_v;
    logic [LSD_CMP_W-1:0] lim_i;
    logic all_valid;
    logic active;
    logic gate;
    logic ctrl_en;
    logic [LSD_THR_W-1:0] vthr;
    logic [LSD_THR_W-1:0] ithr;
    lsd_state_e state;
    lsd_state_e next_state;
    logic setup;
    logic aligned;
    logic mapped;
    logic rd_only;
    logic bad_val;
    logic bus_err;
    logic wr_fire;
    logic [31:0] rd_data;
    logic [2:0] mag_sel;

    // ------------------------------------------------------------
    // Magnitude estimation
    // ------------------------------------------------------------
    always_comb
    begin
        smp_arr[0] = phase_a_voltage; // [R1]
        smp_arr[1] = phase_b_voltage;
        smp_arr[2] = phase_c_voltage;
        smp_arr[3] = phase_a_current;
        smp_arr[4] = phase_b_current;
        smp_arr[5] = phase_c_current;
    end

    for (genvar ch = 0; ch < LSD_NCH; ch++)
    begin : g_est
        lsd_fund_est u_est (
            .pclk(pclk),
            .presetn(presetn),
            .smp_valid(smp_valid),
            .smp(smp_arr[ch]),
            .mag(mag_arr[ch]),
            .mag_valid(mag_ok[ch])
        ); // [R2]
    end

    // ------------------------------------------------------------
    // Threshold comparison
    // ------------------------------------------------------------
    // Scaled limit is threshold times nominal; magnitude is scaled by 100
    always_comb
    begin
        lim_v = LSD_CMP_W'(vthr * LSD_NOM_V); // [R12]
        lim_i = LSD_CMP_W'(ithr * LSD_NOM_I);
        for (int k = 0; k < LSD_NCH; k++)
        begin
            if (k < 3)
                above[k] = LSD_CMP_W'(mag_arr[k] * LSD_PCT_FULL) > lim_v; // [R9]
            else
                above[k] = LSD_CMP_W'(mag_arr[k] * LSD_PCT_FULL) > lim_i; // [R10]
        end
    end

    // ------------------------------------------------------------
    // Operating state
    // ------------------------------------------------------------
    assign all_valid = &mag_ok;
    assign active = ctrl_en && !block_in; // [R8]
    assign gate = (state == LSD_ST_RUN) && active;

    always_comb
    begin
        next_state = state;
        case (state)
            LSD_ST_FILL:
                if (all_valid)
                    next_state = active ? LSD_ST_RUN : LSD_ST_HOLD; // [R13]
            LSD_ST_RUN:
                if (!active)
                    next_state = LSD_ST_HOLD; // [R5]
            LSD_ST_HOLD:
                if (active)
                    next_state = LSD_ST_RUN;
            default:
                next_state = LSD_ST_FILL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= LSD_ST_FILL;
        else
            state <= next_state;
    end

    // ------------------------------------------------------------
    // Flags and decision
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            volt_above_a <= 1'b0;
            volt_above_b <= 1'b0;
            volt_above_c <= 1'b0;
            curr_above_a <= 1'b0;
            curr_above_b <= 1'b0;
            curr_above_c <= 1'b0;
            dead_line_out <= 1'b0;
            live_line_out <= 1'b0;
        end
        else
        begin
            volt_above_a <= gate && above[0]; // [R9]
            volt_above_b <= gate && above[1];
            volt_above_c <= gate && above[2];
            curr_above_a <= gate && above[3]; // [R10]
            curr_above_b <= gate && above[4];
            curr_above_c <= gate && above[5];
            dead_line_out <= gate && (above == '0); // [R3] [R11]
            live_line_out <= gate && (&above[2:0]); // [R4] [R11]
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign aligned = (paddr[1:0] == 2'b00);
    assign mapped = aligned && (paddr <= LSD_OFF_MAG5);
    assign rd_only = (paddr >= LSD_OFF_STAT);
    assign mag_sel = 3'((paddr - LSD_OFF_MAG0) >> 2);

    // Threshold writes outside the range are refused, not clamped
    always_comb
    begin
        bad_val = 1'b0;
        if (paddr == LSD_OFF_VTHR)
            bad_val = (pwdata[31:7] != '0) || (pwdata[6:0] < LSD_VTHR_MIN)
                || (pwdata[6:0] > LSD_VTHR_MAX); // [R6]
        else if (paddr == LSD_OFF_ITHR)
            bad_val = (pwdata[31:7] != '0) || (pwdata[6:0] < LSD_ITHR_MIN)
                || (pwdata[6:0] > LSD_ITHR_MAX); // [R7]
    end

    assign bus_err = !mapped || (pwrite && (rd_only || bad_val));
    assign wr_fire = psel && penable && pready && pwrite && !pslverr;

    always_comb
    begin
        rd_data = '0;
        case (paddr)
            LSD_OFF_CTRL: rd_data[LSD_CTRL_EN_BIT] = ctrl_en;
            LSD_OFF_VTHR: rd_data[LSD_THR_W-1:0] = vthr;
            LSD_OFF_ITHR: rd_data[LSD_THR_W-1:0] = ithr;
            LSD_OFF_STAT:
            begin
                rd_data[LSD_STAT_VOLT_LSB +: 3] = {volt_above_c, volt_above_b, volt_above_a};
                rd_data[LSD_STAT_CURR_LSB +: 3] = {curr_above_c, curr_above_b, curr_above_a};
                rd_data[LSD_STAT_DEAD_BIT] = dead_line_out;
                rd_data[LSD_STAT_LIVE_BIT] = live_line_out;
                rd_data[LSD_STAT_READY_BIT] = all_valid;
                rd_data[LSD_STAT_ST_LSB +: 3] = state;
            end
            default:
                if (mapped && paddr >= LSD_OFF_MAG0)
                    rd_data[LSD_MAG_W-1:0] = mag_arr[mag_sel];
        endcase
    end

    // No wait states: answer is registered at the setup edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && bus_err;
            if (setup && !pwrite)
                prdata <= bus_err ? 32'h0000_0000 : rd_data;
        end
    end

    // ------------------------------------------------------------
    // Settings registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_en <= LSD_EN_RST; // [R5]
            vthr <= LSD_VTHR_RST; // [R6]
            ithr <= LSD_ITHR_RST; // [R7]
        end
        else if (wr_fire)
        begin
            if (paddr == LSD_OFF_CTRL)
                ctrl_en <= pwdata[LSD_CTRL_EN_BIT];
            if (paddr == LSD_OFF_VTHR)
                vthr <= pwdata[LSD_THR_W-1:0];
            if (paddr == LSD_OFF_ITHR)
                ithr <= pwdata[LSD_THR_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_dead_all_low: assert property (dead_line_out |-> // [R3]
        !volt_above_a && !volt_above_b && !volt_above_c
        && !curr_above_a && !curr_above_b && !curr_above_c)
        else $error("dead line with a flag above threshold");

    chk_live_all_volt: assert property (live_line_out |-> // [R4]
        volt_above_a && volt_above_b && volt_above_c)
        else $error("live line without all voltages above");

    chk_off_quiet: assert property (!ctrl_en |=> // [R5]
        !dead_line_out && !live_line_out && !volt_above_a && !volt_above_b
        && !volt_above_c && !curr_above_a && !curr_above_b && !curr_above_c)
        else $error("outputs active while disabled");

    chk_thr_volt_range: assert property (vthr >= LSD_VTHR_MIN && vthr <= LSD_VTHR_MAX) // [R6]
        else $error("voltage threshold out of range");

    chk_thr_curr_range: assert property (ithr >= LSD_ITHR_MIN && ithr <= LSD_ITHR_MAX) // [R7]
        else $error("current threshold out of range");

    chk_block_quiet: assert property (block_in |=> // [R8]
        !dead_line_out && !live_line_out && !volt_above_a && !volt_above_b
        && !volt_above_c && !curr_above_a && !curr_above_b && !curr_above_c)
        else $error("outputs active while blocked");

    chk_volt_follow: assert property (gate |=> // [R9]
        volt_above_a == $past(above[0]) && volt_above_b == $past(above[1])
        && volt_above_c == $past(above[2]))
        else $error("voltage flag does not follow comparison");

    chk_curr_follow: assert property (gate |=> // [R10]
        curr_above_a == $past(above[3]) && curr_above_b == $past(above[4])
        && curr_above_c == $past(above[5]))
        else $error("current flag does not follow comparison");

    chk_dead_follow: assert property (gate |=> // [R3] [R11]
        dead_line_out == ($past(above) == 6'h00))
        else $error("dead line does not follow comparisons");

    chk_live_follow: assert property (gate |=> // [R4] [R11]
        live_line_out == (&$past(above[2:0])))
        else $error("live line does not follow voltage comparisons");

    chk_state_excl: assert property (!(dead_line_out && live_line_out)) // [R11]
        else $error("dead and live at once");

    chk_fill_quiet: assert property (!all_valid |=> // [R13]
        !dead_line_out && !live_line_out && !volt_above_a && !volt_above_b
        && !volt_above_c && !curr_above_a && !curr_above_b && !curr_above_c)
        else $error("output before first window");

    chk_apb_answer: assert property (setup |=> pready ##1 !pready)
        else $error("answer not one cycle after setup");

    chk_err_no_store: assert property (psel && penable && pready && pslverr |=> // [R6] [R7]
        $stable(vthr) && $stable(ithr) && $stable(ctrl_en))
        else $error("refused write changed a setting");

    chk_err_rd_zero: assert property (setup && !pwrite && bus_err |=> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    cov_dead: cover property (gate ##1 dead_line_out);
    cov_live: cover property (gate ##1 live_line_out);
    cov_block_run: cover property (state == LSD_ST_RUN && block_in ##1 state == LSD_ST_HOLD);
    cov_vthr_write: cover property (wr_fire && paddr == LSD_OFF_VTHR);
    cov_fill_done: cover property ($rose(all_valid));

endmodule

// ### hw/lsd_pkg.sv
// Constants and types for the line state detector.
// Assumes one 125 MHz clock and a front end with a sample strobe.
package lsd_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] LSD_OFF_CTRL = 8'h00;
    localparam logic [7:0] LSD_OFF_VTHR = 8'h04;
    localparam logic [7:0] LSD_OFF_ITHR = 8'h08;
    localparam logic [7:0] LSD_OFF_STAT = 8'h0c;
    localparam logic [7:0] LSD_OFF_MAG0 = 8'h10;
    localparam logic [7:0] LSD_OFF_MAG5 = 8'h24;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int LSD_CTRL_EN_BIT = 0;
    localparam int LSD_STAT_VOLT_LSB = 0;
    localparam int LSD_STAT_CURR_LSB = 3;
    localparam int LSD_STAT_DEAD_BIT = 6;
    localparam int LSD_STAT_LIVE_BIT = 7;
    localparam int LSD_STAT_READY_BIT = 8;
    localparam int LSD_STAT_ST_LSB = 9;
    localparam int LSD_THR_W = 7;
    localparam logic LSD_EN_RST = 1'h0;
    localparam logic [6:0] LSD_VTHR_RST = 7'h3c;
    localparam logic [6:0] LSD_VTHR_MIN = 7'h0a;
    localparam logic [6:0] LSD_VTHR_MAX = 7'h64;
    localparam logic [6:0] LSD_ITHR_RST = 7'h0a;
    localparam logic [6:0] LSD_ITHR_MIN = 7'h02;
    localparam logic [6:0] LSD_ITHR_MAX = 7'h64;
    localparam logic [6:0] LSD_PCT_FULL = 7'h64;

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    localparam int LSD_SMP_W = 16;
    localparam int LSD_COEF_W = 8;
    localparam int LSD_ACC_W = 28;
    localparam int LSD_MAG_W = 17;
    localparam int LSD_MAG_SHIFT = 9;
    localparam int LSD_CMP_W = 25;
    localparam int LSD_NCH = 6;
    localparam logic [3:0] LSD_WIN_LAST = 4'hf;
    localparam logic [15:0] LSD_NOM_V = 16'h4000;
    localparam logic [15:0] LSD_NOM_I = 16'h4000;

    typedef enum logic [2:0] {
        LSD_ST_FILL = 3'b001,
        LSD_ST_RUN = 3'b010,
        LSD_ST_HOLD = 3'b100
    } lsd_state_e;

endpackage

// ### hw/lsd_fund_est.sv
// Fundamental magnitude estimator for one sampled channel.
// Assumes sixteen samples per fundamental period, one per strobe.
module lsd_fund_est
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Samples
    input wire logic smp_valid,
    input wire logic signed [LSD_SMP_W-1:0] smp,
    // Magnitude
    output logic [LSD_MAG_W-1:0] mag,
    output logic mag_valid
);

    logic [3:0] idx;
    logic signed [LSD_ACC_W-1:0] re;
    logic signed [LSD_ACC_W-1:0] im;
    logic signed [LSD_ACC_W-1:0] next_re;
    logic signed [LSD_ACC_W-1:0] next_im;
    logic [LSD_ACC_W-1:0] abs_re;
    logic [LSD_ACC_W-1:0] abs_im;
    logic [LSD_ACC_W:0] approx;
    logic signed [LSD_SMP_W+LSD_COEF_W-1:0] prod_re;
    logic signed [LSD_SMP_W+LSD_COEF_W-1:0] prod_im;

    // ------------------------------------------------------------
    // Cosine table, 64 * cos(2*pi*k/16)
    // ------------------------------------------------------------
    function automatic logic signed [LSD_COEF_W-1:0] lsd_cos(input logic [3:0] k);
        case (k)
            4'h0: return 8'sh40;
            4'h1, 4'hf: return 8'sh3b;
            4'h2, 4'he: return 8'sh2d;
            4'h3, 4'hd: return 8'sh18;
            4'h5, 4'hb: return -8'sh18;
            4'h6, 4'ha: return -8'sh2d;
            4'h7, 4'h9: return -8'sh3b;
            4'h8: return -8'sh40;
            default: return 8'sh00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Single-bin correlation over one window
    // ------------------------------------------------------------
    always_comb
    begin
        prod_re = smp * lsd_cos(idx);
        prod_im = smp * lsd_cos(idx - 4'h4);
        next_re = re + LSD_ACC_W'(prod_re);
        next_im = im + LSD_ACC_W'(prod_im);
        abs_re = next_re[LSD_ACC_W-1] ? LSD_ACC_W'(-next_re) : next_re;
        abs_im = next_im[LSD_ACC_W-1] ? LSD_ACC_W'(-next_im) : next_im;
        // Max plus half of min approximates the vector length
        if (abs_re > abs_im)
            approx = {1'b0, abs_re} + {2'b00, abs_im[LSD_ACC_W-1:1]};
        else
            approx = {1'b0, abs_im} + {2'b00, abs_re[LSD_ACC_W-1:1]};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            idx <= 4'h0;
            re <= '0;
            im <= '0;
            mag <= '0;
            mag_valid <= 1'b0;
        end
        else if (smp_valid)
        begin
            idx <= idx + 4'h1;
            if (idx == LSD_WIN_LAST)
            begin
                re <= '0;
                im <= '0;
                mag <= approx[LSD_MAG_SHIFT+LSD_MAG_W-1:LSD_MAG_SHIFT]; // [R2]
                mag_valid <= 1'b1;
            end
            else
            begin
                re <= next_re;
                im <= next_im;
            end
        end
    end

    chk_est_window_done: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (smp_valid && idx == LSD_WIN_LAST) |=> mag_valid)
        else $error("window end did not mark magnitude valid");

endmodule

// ### verification/lsd_front_end.sv
// Behavioural model of the sampled three-phase measurement front end.
// Assumes the bench holds amplitudes steady for several windows at a time.
module lsd_front_end
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the bench
    input wire logic run,
    input wire logic [1:0] gap,
    input wire logic [95:0] amps,
    // Samples: Va, Vb, Vc, Ia, Ib, Ic
    output logic smp_valid,
    output logic signed [LSD_SMP_W-1:0] smp [6]
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] ph;
    logic [1:0] wait_cnt;

    // Sine of 2*pi*k/16, scaled by 1000
    function automatic int sine_k(input logic [3:0] k);
        int t [8] = '{0, 383, 707, 924, 1000, 924, 707, 383};
        return k[3] ? -t[k[2:0]] : t[k[2:0]];
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph <= 4'h0;
            wait_cnt <= 2'h0;
            smp_valid <= 1'b0;
            smp <= '{default: '0};
        end
        else if (run && wait_cnt == 2'h0)
        begin
            smp_valid <= 1'b1;
            ph <= ph + 4'h1;
            wait_cnt <= gap;
            for (int i = 0; i < 6; i++)
            begin
                smp[i] <= LSD_SMP_W'((int'(amps[16*i +: 16]) * sine_k(ph)) / 1000);
            end
        end
        else
        begin
            smp_valid <= 1'b0;
            if (wait_cnt != 2'h0)
                wait_cnt <= wait_cnt - 2'h1;
            // Stale samples are scrambled between strobes
            for (int i = 0; i < 6; i++)
            begin
                smp[i] <= ~smp[i];
            end
        end
    end
endmodule

// ### verification/lsd_line_state_detector_tb.sv
// Self-checking bench for the line state detector.
// Assumes the front end model file and the design files are compiled first.
module lsd_line_state_detector_tb
    import lsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] AMP_HI = 16'h3e80;
    localparam logic [15:0] AMP_VLO = 16'h07d0;
    localparam logic [15:0] AMP_ILO = 16'h0190;

    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic block_in = 1'b0;
    logic run = 1'b0;
    logic [1:0] gap = 2'h0;
    logic [95:0] amps = '0;
    logic smp_valid;
    logic signed [LSD_SMP_W-1:0] smp [6];
    logic [5:0] flags;
    logic dead_line_out;
    logic live_line_out;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 50743;
    int en_m = 0;
    int blk_m = 0;
    int fill_m = 0;
    int vt_m = 60;
    int it_m = 10;
    int pat_m = 0;
    int patq [$] = '{63, 0, 7, 56};
    // Write table: address, data, refusal expected
    logic [7:0] wa [14] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08,
                            8'h08, 8'h08, 8'h08, 8'h08, 8'h0c, 8'h28, 8'h02};
    logic [31:0] wd [14] = '{32'h0a, 32'h64, 32'h3c, 32'h09, 32'h65, 32'h8000003c,
                             32'h02, 32'h64, 32'h0a, 32'h01, 32'h65, 32'h0, 32'h0, 32'h0};
    logic we [14] = '{0, 0, 0, 1, 1, 1, 0, 0, 0, 1, 1, 1, 1, 1};

    always #4 pclk = ~pclk;

    lsd_line_state_detector dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .smp_valid(smp_valid),
        .phase_a_voltage(smp[0]), .phase_b_voltage(smp[1]), .phase_c_voltage(smp[2]),
        .phase_a_current(smp[3]), .phase_b_current(smp[4]), .phase_c_current(smp[5]),
        .block_in(block_in), .volt_above_a(flags[0]), .volt_above_b(flags[1]),
        .volt_above_c(flags[2]), .curr_above_a(flags[3]), .curr_above_b(flags[4]),
        .curr_above_c(flags[5]), .dead_line_out(dead_line_out),
        .live_line_out(live_line_out)
    );

    lsd_front_end fe (
        .pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .amps(amps),
        .smp_valid(smp_valid), .smp(smp)
    );

    // ----------------------------------------
    // Reference model and compares
    // ----------------------------------------
    function automatic logic [7:0] model();
        logic [5:0] f;
        int amp;
        for (int i = 0; i < 6; i++)
        begin
            amp = pat_m[i] ? int'(AMP_HI) : (i < 3 ? int'(AMP_VLO) : int'(AMP_ILO));
            f[i] = amp * int'(LSD_PCT_FULL) >
                   (i < 3 ? vt_m * int'(LSD_NOM_V) : it_m * int'(LSD_NOM_I));
        end
        if (!fill_m || !en_m || blk_m)
            return 8'h00;
        return {&f[2:0], f == 6'h00, f};
    endfunction

    task automatic chk_bits(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Answer taken at the rising edge where pready is seen high
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        chk_reg("pready", 32'h1, n);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_chk(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           input logic exp_err, input logic [31:0] exp_rd);
        apb(wr, a, d);
        chk_reg("pslverr", {31'h0, exp_err}, {31'h0, er});
        if (!wr)
            chk_reg("prdata", exp_rd, rd);
    endtask

    task automatic set_pat(input int p, input int g);
        @(posedge pclk);
        pat_m = p;
        gap <= 2'(g);
        for (int i = 0; i < 6; i++)
        begin
            amps[16*i +: 16] <= p[i] ? AMP_HI : (i < 3 ? AMP_VLO : AMP_ILO);
        end
    endtask

    task automatic settle();
        // Worst-case strobe spacing of four cycles
        repeat (36 * 4 + 6) @(posedge pclk);
    endtask

    task automatic check_outs();
        @(negedge pclk);
        chk_bits("line outputs", model(), {live_line_out, dead_line_out, flags});
        @(posedge pclk);
    endtask

    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb_chk(1'b0, LSD_OFF_CTRL, 32'h0, 1'b0, 32'h0);
        apb_chk(1'b0, LSD_OFF_VTHR, 32'h0, 1'b0, 32'h3c);
        apb_chk(1'b0, LSD_OFF_ITHR, 32'h0, 1'b0, 32'h0a);
        for (int i = 0; i < 14; i++)
            apb_chk(1'b1, wa[i], wd[i], we[i], 32'h0);
        apb_chk(1'b0, LSD_OFF_VTHR, 32'h0, 1'b0, 32'h3c);
        apb_chk(1'b0, LSD_OFF_ITHR, 32'h0, 1'b0, 32'h0a);
        apb_chk(1'b0, 8'h28, 32'h0, 1'b1, 32'h0);
        apb_chk(1'b1, LSD_OFF_CTRL, 32'h1, 1'b0, 32'h0);
        en_m = 1;
        set_pat(63, 0);
        run <= 1'b1;
        repeat (14) @(posedge pclk);
        check_outs();
        settle();
        fill_m = 1;
        check_outs();
        repeat (8) patq.push_back($random(seed) & 63);
        foreach (patq[i])
        begin
            set_pat(patq[i], $random(seed) & 3);
            settle();
            check_outs();
            apb(1'b0, LSD_OFF_STAT, 32'h0);
            chk_reg("status", {20'h0, 3'h2, 1'h1, model()}, rd & 32'hfff);
        end
        apb_chk(1'b1, LSD_OFF_VTHR, 32'h0a, 1'b0, 32'h0);
        apb_chk(1'b1, LSD_OFF_ITHR, 32'h02, 1'b0, 32'h0);
        vt_m = 10;
        it_m = 2;
        set_pat(0, 0);
        settle();
        check_outs();
        set_pat(63, 1);
        settle();
        block_in <= 1'b1;
        blk_m = 1;
        repeat (2) @(posedge pclk);
        check_outs();
        block_in <= 1'b0;
        blk_m = 0;
        settle();
        check_outs();
        apb_chk(1'b1, LSD_OFF_CTRL, 32'h0, 1'b0, 32'h0);
        en_m = 0;
        repeat (2) @(posedge pclk);
        check_outs();
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        wrap_up();
    end
endmodule
